// ==== hw/can_diag_pkg.sv ====
/*
  Package for the CAN status and diagnostic block: register offsets,
  field layouts, reset values, field codes and packed carriers.
  Assumes a 32-bit Avalon-MM slave with word-aligned registers.
*/
package can_diag_pkg;

  localparam int addr_w = 4;
  localparam int n_buf = 15;

  // Register byte offsets
  localparam logic [addr_w-1:0] off_global_config = 4'h0;
  localparam logic [addr_w-1:0] off_code_enable = 4'h4;
  localparam logic [addr_w-1:0] off_pending = 4'h8;
  localparam logic [addr_w-1:0] off_error_counters = 4'hc;

  localparam logic [addr_w-1:0] off_error_diagnostic = 4'h0;
  localparam logic [addr_w-1:0] off_bit_time_counter = 4'h4;

  // Register select: the upper address bit picks the second bank
  localparam int bank_bit = 4;

  // Global configuration bit positions
  localparam int cfg_enable_bit = 0;
  localparam int cfg_tstamp_bit = 1;
  localparam int cfg_txinv_bit = 2;
  localparam int cfg_rxinv_bit = 3;
  localparam int cfg_width = 4;

  // Pending, clear and code enable layout
  localparam int err_bit = 15;

  // Reset values
  localparam logic [cfg_width-1:0] cfg_reset = 4'h0;
  localparam logic [15:0] mask_reset = 16'h0000;
  localparam logic [15:0] pend_reset = 16'h0000;
  localparam logic [15:0] timer_reset = 16'h0000;

  // Interrupt code
  localparam logic [4:0] code_none = 5'h00;
  localparam logic [4:0] code_error = 5'h10;
  localparam logic [3:0] code_buf_base = 4'h1;

  // Diagnostic field positions
  localparam int diag_drive_bit = 14;
  localparam int diag_mon_bit = 13;
  localparam int diag_crc_bit = 12;
  localparam int diag_stuff_bit = 11;
  localparam int diag_txe_bit = 10;
  localparam int diag_pos_lsb = 4;
  localparam int diag_field_lsb = 0;

  // Frame field codes
  typedef enum logic [3:0] {
    fld_error_flag = 4'h0,
    fld_error_delim = 4'h1,
    fld_error_echo = 4'h2,
    fld_bus_idle = 4'h3,
    fld_ack = 4'h4,
    fld_eof = 4'h5,
    fld_intermission = 4'h6,
    fld_suspend = 4'h7,
    fld_sof = 4'h8,
    fld_arbitration = 4'h9,
    fld_id_ext = 4'ha,
    fld_ext_arbitration = 4'hb,
    fld_reserved_bits = 4'hc,
    fld_length_code = 4'hd,
    fld_data = 4'he,
    fld_checksum = 4'hf
  } field_code_t;

  // Event from the protocol engine about the bus
  typedef struct packed {
    logic bit_tick;
    logic field_start;
    field_code_t field;
    logic [5:0] field_len;
    logic transmitting;
    logic tx_level;
    logic error;
    logic stuff_error;
    logic crc_error;
  } engine_event_t;

  // Captured diagnostic
  typedef struct packed {
    logic reserved;
    logic drive;
    logic mon;
    logic crc;
    logic stuff;
    logic was_transmitter_flag;
    logic [5:0] pos;
    field_code_t field;
  } diag_t;

  typedef enum logic [1:0] {
    bus_idle = 2'b01,
    bus_answer = 2'b10
  } bus_state_t;

endpackage : can_diag_pkg

// ==== hw/can_error_diag_status.sv ====
/*
  CAN status and diagnostic block: interrupt code, error counters,
  error diagnostic capture, bit-time counter and bus pin polarity.
  Assumes a protocol engine beside it that supplies bus bit ticks,
  field starts, error events, counters and buffer completion events,
  and an Avalon-MM master with waitrequest on the register side.
*/
// Function
// R1 - Code zero idle, error 10, buffer n+1; the code also sets bit 4 for buffers, so buffer n gets 11+n
// R2 - Code shows only pending and enabled sources
// R3 - Error beats buffers, lower buffers win
// R4 - Counter change sets sticky error pending
// R5 - Counters read rx high, tx low
// R6 - Diagnostic read-only, laid out as documented
// R7 - Field codes zero to seven recorded
// R8 - Field codes eight to fifteen recorded
// R9 - Field bit counter loads length, counts down
// R10 - Capture whether node was transmitting
// R11 - Capture stuffing rule violation
// R12 - Capture checksum error flag
// R13 - Capture rx and tx pin levels
// R14 - Receiver drives dominant only ack, error
// R15 - Free-running 16-bit bit counter from zero
// R16 - Buffer 0 transfer resets counter if enabled
// R17 - Time stamp offered on each completed frame
// R18 - Software configures before global enable
// R19 - Software checks no pending transmit first
// R20 - Disable also disables rx pin path
// R21 - Software re-enables after wake; state kept
// R22 - Tx and rx pins each have inversion
`timescale 1ns/100ps
`default_nettype none

module can_error_diag_status
  import can_diag_pkg::*;
#(
  parameter int buffers = n_buf
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [addr_w:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  // Protocol engine side
  input wire engine_event_t engine,
  input wire logic [7:0] rx_error_count,
  input wire logic [7:0] tx_error_count,
  input wire logic [buffers-1:0] buffer_done,
  input wire logic engine_tx_bit,
  output logic engine_rx_bit,
  output logic controller_enable,
  output logic [15:0] timestamp,
  output logic [buffers-1:0] timestamp_store,
  // Bus pins
  output logic bus_tx_pin,
  input wire logic bus_rx_pin
);

  bus_state_t state;
  bus_state_t next_state;
  logic [cfg_width-1:0] global_config_register;
  logic [15:0] interrupt_code_enable_mask;
  logic [buffers-1:0] buf_pending;
  logic error_irq_pending;
  logic [15:0] error_counters;
  logic [15:0] bit_time_counter;
  logic [5:0] field_bits;
  diag_t error_diagnostic;
  logic [4:0] interrupt_source_code;

  // Request decode
  wire logic access = read | write;
  wire logic bank = address[bank_bit];
  wire logic [addr_w-1:0] offs = address[addr_w-1:0];
  wire logic sel_cfg = !bank && offs == off_global_config;
  wire logic sel_mask = !bank && offs == off_code_enable;
  wire logic sel_pend = !bank && offs == off_pending;
  wire logic sel_cnt = !bank && offs == off_error_counters;
  wire logic sel_diag = bank && offs == off_error_diagnostic;
  wire logic sel_tmr = bank && offs == off_bit_time_counter;
  wire logic mapped = sel_cfg | sel_mask | sel_pend | sel_cnt | sel_diag | sel_tmr;
  wire logic take = state == bus_answer;
  wire logic start = access && state == bus_idle;

  // Write strobes; only the low two byte lanes carry register bits
  wire logic wr_take = take && write;
  wire logic wr_lo = wr_take && byteenable[0];
  wire logic wr_hi = wr_take && byteenable[1];
  wire logic [7:0] clr_lo = wr_lo ? writedata[7:0] : 8'h00;
  wire logic [7:0] clr_hi = wr_hi ? writedata[15:8] : 8'h00;
  wire logic [15:0] clr_bits = {clr_hi, clr_lo};
  wire logic clr_req = sel_pend && wr_take;
  wire logic clr_err = clr_req && clr_bits[err_bit];
  wire logic [buffers-1:0] clr_buf = clr_req ? clr_bits[buffers-1:0] : '0;

  // Configuration fields
  wire logic enabled = global_config_register[cfg_enable_bit];
  wire logic tstamp_en = global_config_register[cfg_tstamp_bit];
  wire logic tx_inv = global_config_register[cfg_txinv_bit];
  wire logic rx_inv = global_config_register[cfg_rxinv_bit];

  // Receive path; a disabled controller hears only recessive, so no wake-up via it
  wire logic rx_logical = bus_rx_pin ^ rx_inv; // see R22
  wire logic rx_level = enabled ? rx_logical : 1'b1; // see R20

  // Transmit path; a receiver may only go dominant in ack or error flag
  wire logic in_ack_slot = engine.field == fld_ack;
  wire logic in_error_flag = engine.field == fld_error_flag;
  wire logic rx_may_drive = in_ack_slot || in_error_flag; // see R14
  wire logic may_drive = engine.transmitting || rx_may_drive; // see R14
  wire logic tx_level = (enabled && may_drive) ? engine_tx_bit : 1'b1; // see R14
  wire logic next_tx_pin = tx_level ^ tx_inv; // see R22

  // Interrupt code chain; lower buffers sit nearer the end and win
  wire logic [15:0] active = {error_irq_pending, buf_pending} & interrupt_code_enable_mask; // see R2
  wire logic [4:0] chain_code [buffers:0];
  assign chain_code[buffers] = code_none; // see R1
  for (genvar g = 0; g < buffers; g++) begin : g_prio
    wire logic [3:0] buf_code = 4'(g) + code_buf_base;
    assign chain_code[g] = active[g] ? {1'b1, buf_code} : chain_code[g + 1]; // see R1 R3
  end
  assign interrupt_source_code = active[err_bit] ? code_error : chain_code[0]; // see R3
  wire logic code_valid = interrupt_source_code != code_none;

  // Error counters and pending flags; a set in the clear cycle wins
  wire logic [15:0] next_counters = {rx_error_count, tx_error_count}; // see R5
  wire logic counters_changed = next_counters != error_counters;
  wire logic next_error_pending = counters_changed || (error_irq_pending && !clr_err); // see R4
  wire logic [buffers-1:0] next_buf_pending = buffer_done | (buf_pending & ~clr_buf);

  // Configuration and code enable mask, byte by byte
  wire logic cfg_load = sel_cfg && wr_lo;
  wire logic [cfg_width-1:0] next_config = cfg_load ? writedata[cfg_width-1:0] : global_config_register;
  wire logic [7:0] next_mask_lo = (sel_mask && wr_lo) ? writedata[7:0] : interrupt_code_enable_mask[7:0];
  wire logic [7:0] next_mask_hi = (sel_mask && wr_hi) ? writedata[15:8] : interrupt_code_enable_mask[15:8];

  // Read words; unmapped offsets read zero
  wire logic [15:0] word_cfg = {{(16 - cfg_width){1'b0}}, global_config_register};
  wire logic [15:0] word_pend = {error_irq_pending, code_valid, buf_pending[13:0]};
  wire logic [15:0] word_diag = error_diagnostic; // see R6
  wire logic [15:0] read_word = ({16{sel_cfg}} & word_cfg) |
    ({16{sel_mask}} & interrupt_code_enable_mask) |
    ({16{sel_pend}} & word_pend) |
    ({16{sel_cnt}} & error_counters) |
    ({16{sel_diag}} & word_diag) |
    ({16{sel_tmr}} & bit_time_counter);

  // Field bit counter
  wire logic [5:0] len_less_one = engine.field_len - 6'h01; // see R9
  wire logic [5:0] bits_less_one = field_bits - 6'h01; // see R9
  wire logic [5:0] next_field_bits = engine.field_start ? len_less_one :
    engine.bit_tick ? bits_less_one : field_bits;

  // Diagnostic snapshot; drive is the level before pin inversion
  wire diag_t captured = '{
    reserved: 1'b0, // see R6
    drive: bus_tx_pin ^ tx_inv, // see R13
    mon: rx_level, // see R13
    crc: engine.crc_error, // see R12
    stuff: engine.stuff_error, // see R11
    was_transmitter_flag: engine.transmitting, // see R10
    pos: field_bits, // see R9
    field: engine.field // see R7 R8
  };

  // Bit-time counter; wraps silently at the top
  wire logic timer_sync = tstamp_en && buffer_done[0]; // see R16
  wire logic [15:0] bit_time_plus = bit_time_counter + 16'h0001; // see R15
  wire logic [15:0] next_bit_time = timer_sync ? timer_reset :
    engine.bit_tick ? bit_time_plus : bit_time_counter;

  always_comb begin
    next_state = state;
    unique case (state)
      bus_idle: begin
        if (access) begin
          next_state = bus_answer;
        end
      end
      bus_answer: begin
        next_state = bus_idle;
      end
    endcase
  end

  // Bus answer: one wait cycle, then the request is taken
  assign waitrequest = !take;
  assign response = (take && !mapped) ? 2'b10 : 2'b00;

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= bus_idle;
      readdata <= 32'h00000000;
    end else begin
      state <= next_state;
      if (start) begin
        readdata <= {16'h0000, read_word};
      end
    end
  end

  // Configuration and mask
  always_ff @(posedge mclk) begin
    if (reset) begin
      global_config_register <= cfg_reset;
      interrupt_code_enable_mask <= mask_reset;
    end else begin
      global_config_register <= next_config;
      interrupt_code_enable_mask <= {next_mask_hi, next_mask_lo};
    end
  end

  // Counters and sticky pending flags
  always_ff @(posedge mclk) begin
    if (reset) begin
      error_irq_pending <= 1'b0;
      buf_pending <= '0;
      error_counters <= 16'h0000;
    end else begin
      error_counters <= next_counters; // see R5
      error_irq_pending <= next_error_pending; // see R4
      buf_pending <= next_buf_pending;
    end
  end

  // Field bit counter and diagnostic capture
  always_ff @(posedge mclk) begin
    if (reset) begin
      field_bits <= 6'h00;
      error_diagnostic <= '0; // see R6
    end else begin
      field_bits <= next_field_bits; // see R9
      if (engine.error) begin
        error_diagnostic <= captured; // see R7 R8 R10 R11 R12 R13
      end
    end
  end

  // Bit-time counter
  always_ff @(posedge mclk) begin
    if (reset) begin
      bit_time_counter <= timer_reset; // see R15
    end else begin
      bit_time_counter <= next_bit_time; // see R15 R16
    end
  end

  // Time stamp handed to the buffer store; the value is pre-reset
  assign timestamp = bit_time_counter; // see R17
  assign timestamp_store = buffer_done; // see R17

  always_ff @(posedge mclk) begin
    if (reset) begin
      bus_tx_pin <= 1'b1;
    end else begin
      bus_tx_pin <= next_tx_pin; // see R22
    end
  end

  assign engine_rx_bit = rx_level;
  assign controller_enable = enabled; // see R21

endmodule : can_error_diag_status

`default_nettype wire

// ==== testbench/can_diag_monitor.sv ====
/* Port checker for the CAN status block.
   Assumes a bind into can_error_diag_status. */
`timescale 1ns/100ps
`default_nettype none
module can_diag_monitor
  import can_diag_pkg::*;
#(parameter int buffers = n_buf) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register bus
  input wire logic [addr_w:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [1:0] response,
  // Engine and pins
  input wire engine_event_t engine,
  input wire logic [7:0] rx_error_count,
  input wire logic [7:0] tx_error_count,
  input wire logic [buffers-1:0] buffer_done,
  input wire logic engine_rx_bit,
  input wire logic controller_enable,
  input wire logic [15:0] timestamp,
  input wire logic [buffers-1:0] timestamp_store,
  input wire logic bus_rx_pin
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  AST_TS_STORE:
    assert property (timestamp_store == buffer_done) else $error("store strobe wrong");
  AST_RX_OFF:
    assert property (!controller_enable |-> engine_rx_bit) else $error("rx path open");
  AST_TMR_STEP:
    assert property (engine.bit_tick && !buffer_done[0] |=> timestamp == $past(timestamp) + 16'h1)
    else $error("timer missed a bit");
  AST_TMR_HOLD:
    assert property (!engine.bit_tick && !buffer_done[0] |=> $stable(timestamp)) else $error("timer moved");
  AST_ANSWER:
    assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no answer");
  AST_ERR_CNT:
    assert property (read && !waitrequest && address == {1'b0, off_error_counters}
      && $past(rx_error_count, 2) == rx_error_count && $past(tx_error_count, 2) == tx_error_count
      |-> readdata[15:0] == {rx_error_count, tx_error_count}) else $error("counter read wrong");
  AST_RESP:
    assert property (response != 2'b00 |-> !waitrequest && (read || write)) else $error("stray response");
  AST_RX_FOLLOW:
    assert property (controller_enable && $past(controller_enable) && !$past(write) && $changed(bus_rx_pin)
      |-> $changed(engine_rx_bit)) else $error("rx pin not followed");
  cover property (read && !waitrequest && response == 2'b10);
  cover property (buffer_done[0]);
  cover property (engine.error);
endmodule : can_diag_monitor
bind can_error_diag_status can_diag_monitor #(.buffers(buffers)) mon_u (.*);
`default_nettype wire

// ==== testbench/can_error_diag_status_tb.sv ====
/* Self-checking bench for the CAN status block.
   Assumes the register map and one wait cycle of the design. */
`timescale 1ns/100ps
`default_nettype none
module can_error_diag_status_tb
  import can_diag_pkg::*;
();
  logic mclk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0;
  logic [addr_w:0] address = '0;
  logic [31:0] writedata = '0, readdata, rd;
  logic [3:0] byteenable = 4'h3;
  logic waitrequest, engine_rx_bit, controller_enable, bus_tx_pin, bus_rx_pin;
  logic [1:0] response, rr;
  engine_event_t engine = '0;
  logic [7:0] rx_error_count = 8'h00, tx_error_count = 8'h00;
  logic [n_buf-1:0] buffer_done = '0, timestamp_store;
  logic engine_tx_bit = 1'b1, other_dom = 1'b0;
  logic [15:0] timestamp;
  int n_errors = 0, checked = 0;
  always #50 mclk = ~mclk;
  can_error_diag_status dut_u (.*);
  can_transceiver_model xcvr_u (.tx_level(bus_tx_pin), .rx_level(bus_rx_pin), .other_dominant(other_dom));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    rd = readdata;
    rr = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic expect_reg(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : expect_reg
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk) engine.bit_tick <= 1'b1;
      @(posedge mclk) engine.bit_tick <= 1'b0;
    end
  endtask : tick
  task automatic pulse_done(input logic [n_buf-1:0] b);
    @(posedge mclk) buffer_done <= b;
    @(posedge mclk) buffer_done <= '0;
  endtask : pulse_done
  task automatic s_reset_values;
    expect_reg(5'h0c, 32'h0);
    expect_reg(5'h10, 32'h0);
    expect_reg(5'h14, 32'h0);
    expect_reg(5'h18, 32'h0);
    chk({30'h0, rr}, 32'h2);
  endtask : s_reset_values
  task automatic s_error_counts;
    @(posedge mclk) {rx_error_count, tx_error_count} <= 16'ha53c;
    bus(1'b1, 5'h0c, 32'hffff);
    expect_reg(5'h0c, 32'ha53c);
    expect_reg(5'h08, 32'h8000);
    bus(1'b1, 5'h04, 32'h8000);
    expect_reg(5'h08, 32'hc000);
    bus(1'b1, 5'h08, 32'h8000);
    expect_reg(5'h08, 32'h0);
  endtask : s_error_counts
  task automatic s_buffers;
    pulse_done(15'h0088);
    bus(1'b1, 5'h04, 32'h0080);
    expect_reg(5'h08, 32'h4088);
    bus(1'b1, 5'h08, 32'h0080);
    expect_reg(5'h08, 32'h0008);
    bus(1'b1, 5'h08, 32'h0008);
  endtask : s_buffers
  task automatic s_diag;
    logic drv;
    bus(1'b1, 5'h00, 32'h1);
    for (int i = 0; i < 16; i++) begin
      drv = i[0] ? i[1] : 1'b1;
      @(posedge mclk);
      engine.field <= field_code_t'(i[3:0]);
      engine.field_len <= 6'd12;
      engine.field_start <= 1'b1;
      engine.transmitting <= i[0];
      engine_tx_bit <= drv;
      other_dom <= i[2];
      @(posedge mclk) engine.field_start <= 1'b0;
      tick(i % 4);
      @(posedge mclk) {engine.error, engine.crc_error, engine.stuff_error} <= {1'b1, i[3], i[2]};
      @(posedge mclk) {engine.error, engine.crc_error, engine.stuff_error} <= 3'h0;
      expect_reg(5'h10, {17'h0, drv, drv & ~i[2], i[3], i[2], i[0], 6'(11 - i % 4), i[3:0]});
    end
  endtask : s_diag
  task automatic s_timer;
    bus(1'b1, 5'h00, 32'h3);
    pulse_done(15'h1);
    tick(5);
    expect_reg(5'h14, 32'h5);
    bus(1'b1, 5'h00, 32'h1);
    pulse_done(15'h1);
    tick(2);
    expect_reg(5'h14, 32'h7);
    chk({16'h0, timestamp}, 32'h7);
    bus(1'b1, 5'h08, 32'h1);
  endtask : s_timer
  task automatic s_pins;
    @(posedge mclk) {engine.transmitting, engine.field, engine_tx_bit, other_dom} <= {1'b0, fld_data, 2'b00};
    repeat (3) @(posedge mclk);
    chk({31'h0, bus_tx_pin}, 32'h1);
    @(posedge mclk) engine.field <= fld_ack;
    repeat (3) @(posedge mclk);
    chk({31'h0, bus_tx_pin}, 32'h0);
    bus(1'b1, 5'h00, 32'hd);
    repeat (3) @(posedge mclk);
    chk({31'h0, bus_tx_pin}, 32'h1);
    chk({31'h0, engine_rx_bit}, 32'h0);
    @(posedge mclk) other_dom <= 1'b1;
    repeat (2) @(posedge mclk);
    chk({31'h0, engine_rx_bit}, 32'h1);
    @(posedge mclk) other_dom <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({31'h0, engine_rx_bit}, 32'h0);
    bus(1'b1, 5'h00, 32'h0);
    @(posedge mclk);
    chk({31'h0, engine_rx_bit}, 32'h1);
    bus(1'b1, 5'h00, 32'h1);
    expect_reg(5'h00, 32'h1);
  endtask : s_pins
  task automatic print_verdict;
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    s_reset_values;
    s_error_counts;
    s_buffers;
    s_diag;
    s_timer;
    s_pins;
    print_verdict;
  end
  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    print_verdict;
  end
endmodule : can_error_diag_status_tb
`default_nettype wire

// ==== testbench/can_transceiver_model.sv ====
/* Transceiver model: wired-AND of this node and other nodes.
   Assumes 0 is dominant on both pins. */
`timescale 1ns/100ps
`default_nettype none
module can_transceiver_model (
  // Node side
  input wire logic tx_level,
  output logic rx_level,
  // Other nodes
  input wire logic other_dominant
);
  // Any dominant node wins the bus
  assign rx_level = tx_level & ~other_dominant;
endmodule : can_transceiver_model
`default_nettype wire
